// ===== verilog/dbg_pkg.sv
// shared constants and types for the breakpoint debug exception unit
package dbg_pkg;
    localparam int NUM_BP = 4;
    localparam int LBR_DEPTH = 4;
    localparam logic [11:0] OFF_BP0 = 12'h000;
    localparam logic [11:0] OFF_BP1 = 12'h004;
    localparam logic [11:0] OFF_BP2 = 12'h008;
    localparam logic [11:0] OFF_BP3 = 12'h00c;
    localparam logic [11:0] OFF_RSV4 = 12'h010;
    localparam logic [11:0] OFF_RSV5 = 12'h014;
    localparam logic [11:0] OFF_STATUS = 12'h018;
    localparam logic [11:0] OFF_CONTROL = 12'h01c;
    localparam logic [11:0] OFF_MISC = 12'h020;
    localparam logic [11:0] OFF_LBR_TOS = 12'h024;
    localparam logic [11:0] OFF_LBR_FROM = 12'h040;
    localparam logic [11:0] OFF_LBR_TO = 12'h060;
    localparam int ST_BS = 14;
    localparam int ST_BT = 15;
    localparam int ST_BD = 13;
    localparam int CT_GD = 13;
    localparam int CT_KIND_LSB = 16;
    localparam int MISC_BTM = 0;
    localparam int MISC_EXT = 1;
    localparam int MISC_LBR = 2;
    localparam logic [31:0] STATUS_RST = 32'hffff0ff0;
    localparam logic [31:0] CONTROL_RST = 32'h00000400;
    localparam logic [31:0] MISC_RST = 32'h00000002;
    localparam logic [1:0] KIND_EXEC = 2'h0;
    localparam logic [1:0] KIND_WR = 2'h1;
    localparam logic [1:0] KIND_IO = 2'h2;
    localparam logic [1:0] KIND_RW = 2'h3;
    localparam logic [1:0] LEN_1 = 2'h0;
    localparam logic [1:0] LEN_2 = 2'h1;
    localparam logic [1:0] LEN_8 = 2'h2;
    localparam logic [1:0] LEN_4 = 2'h3;
    localparam logic [2:0] MOVE_DR_OPS = 3'h7;

    typedef enum logic [1:0] {
        ACC_FETCH,
        ACC_READ,
        ACC_WRITE,
        ACC_IO
    } acc_kind_t;

    typedef struct packed {
        logic valid;
        acc_kind_t kind;
        logic [31:0] lin_addr;
        logic [1:0] size;
    } access_t;

    typedef struct packed {
        logic valid;
        logic [31:0] from_addr;
        logic [31:0] to_addr;
    } branch_t;

    typedef struct packed {
        logic insn_done;
        logic step_flag;
        logic resume_flag;
        logic task_switch;
        logic task_trap;
        logic soft_bp;
        logic move_dr;
        logic [2:0] move_dr_idx;
        logic move_dr_wr;
        logic [31:0] move_dr_data;
        logic real_mode;
        logic system_management_mode;
        logic [1:0] current_privilege_level;
    } core_evt_t;
endpackage

// ===== verilog/bp_match.sv
// one breakpoint comparator: kind, size and linear address match
`timescale 1ns/1ps
module bp_match (
    // breakpoint setup
    input wire logic [31:0] bp_addr,
    input wire logic [1:0] kind_field,
    input wire logic [1:0] size_field,
    input wire logic ext_on,
    // access under test
    input wire dbg_pkg::access_t acc,
    // result
    output logic hit
);
    logic [31:0] mask;
    logic kind_ok;
    logic [31:0] acc_lo;
    logic [31:0] acc_hi;
    logic [31:0] span;

    always_comb begin
        case (size_field)
            dbg_pkg::LEN_1: mask = 32'hffffffff;
            dbg_pkg::LEN_2: mask = 32'hfffffffe;
            dbg_pkg::LEN_4: mask = 32'hfffffffc;
            default: mask = 32'hfffffff8;
        endcase
        case (kind_field)
            dbg_pkg::KIND_EXEC: kind_ok = acc.kind == dbg_pkg::ACC_FETCH;
            dbg_pkg::KIND_WR: kind_ok = acc.kind == dbg_pkg::ACC_WRITE;
            dbg_pkg::KIND_IO: kind_ok = ext_on && acc.kind == dbg_pkg::ACC_IO;
            default: kind_ok = acc.kind == dbg_pkg::ACC_READ ||
                acc.kind == dbg_pkg::ACC_WRITE;
        endcase
        // size 0..3 means 1,2,4,8 bytes; only the first or last byte of the access may hit
        span = (32'h1 << acc.size) - 32'h1;
        acc_lo = acc.lin_addr & mask;
        acc_hi = (acc.lin_addr + span) & mask;
        // linear compare, no translation involved
        hit = acc.valid && kind_ok && ((acc_lo == (bp_addr & mask)) ||
            (acc_hi == (bp_addr & mask)));
    end
endmodule

// ===== verilog/branch_stack.sv
// ring of recent taken branches with from and to addresses
`timescale 1ns/1ps
module branch_stack (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // capture
    input wire logic enable,
    input wire dbg_pkg::branch_t br,
    // readback
    input wire logic [1:0] rd_idx,
    output logic [31:0] rd_from,
    output logic [31:0] rd_to,
    output logic [1:0] tos
);
    logic [31:0] from_r [dbg_pkg::LBR_DEPTH];
    logic [31:0] to_r [dbg_pkg::LBR_DEPTH];
    logic [1:0] tos_r;
    logic [1:0] tos_nxt;

    always_comb begin
        tos_nxt = tos_r;
        if (enable && br.valid) begin
            tos_nxt = tos_r + 2'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tos_r <= 2'h0;
        end else begin
            tos_r <= tos_nxt;
        end
    end

    // entries need no reset; tos tells software which one is newest
    always_ff @(posedge hclk) begin
        if (enable && br.valid) begin
            from_r[tos_nxt] <= br.from_addr;
            to_r[tos_nxt] <= br.to_addr;
        end
    end

    assign rd_from = from_r[rd_idx];
    assign rd_to = to_r[rd_idx];
    assign tos = tos_r;
endmodule

// ===== verilog/dbg_unit.sv
// breakpoint and debug exception unit with AHB-Lite register access
//
// Overview of operation
// - access hitting breakpoint address raises debug exception
// - four independent breakpoints, numbered zero to three
// - breakpoints compare linear addresses
// - watched size one, two, four or eight bytes
// - match only on programmed access kind
// - disabled breakpoint raises no exception
// - status records each breakpoint condition on exception
// - eight debug registers readable and writable by moves
// - moves only real, SYSTEM_MANAGEMENT_MODE or level zero; else fault
// - single-step flag traps after each instruction
// - task trap flag traps on task switch
// - resume flag suppresses repeat trap on instruction
// - software breakpoint raises separate breakpoint exception
// - debugger invoked on debug register access attempt, read or write
// - stack of recent branches, source and destination
// - optional branch trace message on system bus
// - access kind decode 00 exec 01 write 10 io 11 rw
// - size decode 00 one, 01 two, 11 four, 10 eight
// - exception needs local or global enable; task clears local
// - hit flags set even when breakpoint disabled
`timescale 1ns/1ps
module dbg_unit (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core side
    input wire dbg_pkg::access_t access,
    input wire dbg_pkg::core_evt_t evt,
    input wire dbg_pkg::branch_t branch,
    // exceptions and move results
    output logic debug_exception,
    output logic breakpoint_exception,
    output logic general_protection_fault,
    output logic [31:0] move_rd_data,
    // branch trace message
    output logic btm_valid,
    output logic [63:0] btm_data
);
    logic [31:0] bp_addr_r [dbg_pkg::NUM_BP];
    logic [31:0] bp_addr_nxt [dbg_pkg::NUM_BP];
    logic [31:0] status_r, status_nxt;
    logic [31:0] control_r, control_nxt;
    logic [31:0] misc_r, misc_nxt;
    logic [3:0] cond;
    logic [3:0] enabled;
    logic dbx_nxt, dbx_r, bpx_r, gpf_r;
    logic [31:0] mv_nxt, mv_r;
    logic btm_v_r;
    logic [63:0] btm_d_r;
    logic [11:0] a_addr_r;
    logic a_wr_r, a_act_r;
    logic [31:0] rd_nxt, rd_r;
    logic [31:0] lbr_from, lbr_to;
    logic [1:0] lbr_tos;
    logic priv_ok;
    logic bus_wr;
    logic mv_ok;
    logic gd_trap;
    logic ext_on;
    logic rf_block_r;

    assign ext_on = misc_r[dbg_pkg::MISC_EXT];

    // one comparator per breakpoint, all in parallel
    genvar g;
    generate
        for (g = 0; g < dbg_pkg::NUM_BP; g++) begin : gen_bp
            bp_match u_match (
                .bp_addr(bp_addr_r[g]),
                .kind_field(control_r[dbg_pkg::CT_KIND_LSB + 4*g +: 2]),
                .size_field(control_r[dbg_pkg::CT_KIND_LSB + 4*g + 2 +: 2]),
                .ext_on(ext_on),
                .acc(access),
                .hit(cond[g])
            );
            // local or global enable
            assign enabled[g] = control_r[2*g] | control_r[2*g+1];
        end
    endgenerate

    branch_stack u_lbr (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(misc_r[dbg_pkg::MISC_LBR]),
        .br(branch),
        .rd_idx(a_addr_r[3:2]),
        .rd_from(lbr_from),
        .rd_to(lbr_to),
        .tos(lbr_tos)
    );

    // moves allowed in real mode, smm or level zero
    assign priv_ok = evt.real_mode | evt.system_management_mode | (evt.current_privilege_level == 2'h0);
    assign gd_trap = evt.move_dr & priv_ok & control_r[dbg_pkg::CT_GD];
    assign mv_ok = evt.move_dr & priv_ok & ~control_r[dbg_pkg::CT_GD];
    assign bus_wr = a_act_r & a_wr_r;

    // register state: bus writes, core moves, exception side effects
    always_comb begin
        logic hit_enabled;
        logic step_trap;
        logic task_trap;
        hit_enabled = 1'b0;
        step_trap = 1'b0;
        task_trap = 1'b0;
        for (int i = 0; i < dbg_pkg::NUM_BP; i++) begin
            bp_addr_nxt[i] = bp_addr_r[i];
        end
        status_nxt = status_r;
        control_nxt = control_r;
        misc_nxt = misc_r;
        mv_nxt = mv_r;
        dbx_nxt = 1'b0;
        if (bus_wr) begin
            case (a_addr_r)
                dbg_pkg::OFF_BP0: bp_addr_nxt[0] = hwdata;
                dbg_pkg::OFF_BP1: bp_addr_nxt[1] = hwdata;
                dbg_pkg::OFF_BP2: bp_addr_nxt[2] = hwdata;
                dbg_pkg::OFF_BP3: bp_addr_nxt[3] = hwdata;
                dbg_pkg::OFF_STATUS: status_nxt = hwdata;
                dbg_pkg::OFF_CONTROL: control_nxt = hwdata;
                dbg_pkg::OFF_MISC: misc_nxt = hwdata;
                default: ;
            endcase
        end
        if (mv_ok) begin
            // index 4 and 5 alias status and control
            if (evt.move_dr_wr) begin
                case (evt.move_dr_idx)
                    3'h0, 3'h1, 3'h2, 3'h3:
                        bp_addr_nxt[evt.move_dr_idx[1:0]] = evt.move_dr_data;
                    3'h4, 3'h6: status_nxt = evt.move_dr_data;
                    default: control_nxt = evt.move_dr_data;
                endcase
            end else begin
                case (evt.move_dr_idx)
                    3'h0, 3'h1, 3'h2, 3'h3:
                        mv_nxt = bp_addr_r[evt.move_dr_idx[1:0]];
                    3'h4, 3'h6: mv_nxt = status_r;
                    default: mv_nxt = control_r;
                endcase
            end
        end
        // resume flag masks instruction hits of the restarted instruction
        // flag counts in its own cycle too, not only once registered
        hit_enabled = |(cond & enabled) &
            ~((evt.resume_flag | rf_block_r) &
            access.kind == dbg_pkg::ACC_FETCH);
        step_trap = evt.insn_done & evt.step_flag;
        task_trap = evt.task_switch & evt.task_trap;
        dbx_nxt = hit_enabled | step_trap | task_trap | gd_trap;
        if (evt.task_switch) begin
            // locals only; globals survive a task switch
            control_nxt = control_nxt & ~32'h00000055;
        end
        if (dbx_nxt) begin
            // hit flags are taken from all four, enabled or not
            status_nxt[3:0] = cond;
            if (step_trap) status_nxt[dbg_pkg::ST_BS] = 1'b1;
            if (task_trap) status_nxt[dbg_pkg::ST_BT] = 1'b1;
            if (gd_trap) begin
                status_nxt[dbg_pkg::ST_BD] = 1'b1;
            end
            // handler must reach the registers, so detect is dropped
            control_nxt[dbg_pkg::CT_GD] = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < dbg_pkg::NUM_BP; i++) begin
                bp_addr_r[i] <= 32'h00000000;
            end
            status_r <= dbg_pkg::STATUS_RST;
            control_r <= dbg_pkg::CONTROL_RST;
            misc_r <= dbg_pkg::MISC_RST;
            mv_r <= 32'h00000000;
            dbx_r <= 1'b0;
            bpx_r <= 1'b0;
            gpf_r <= 1'b0;
            rf_block_r <= 1'b0;
        end else begin
            for (int i = 0; i < dbg_pkg::NUM_BP; i++) begin
                bp_addr_r[i] <= bp_addr_nxt[i];
            end
            status_r <= status_nxt;
            control_r <= control_nxt;
            misc_r <= misc_nxt;
            mv_r <= mv_nxt;
            dbx_r <= dbx_nxt;
            bpx_r <= evt.soft_bp;
            gpf_r <= evt.move_dr & ~priv_ok;
            rf_block_r <= evt.resume_flag & ~evt.insn_done;
        end
    end

    // branch trace messages, when switched on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            btm_v_r <= 1'b0;
            btm_d_r <= 64'h0;
        end else begin
            btm_v_r <= branch.valid & misc_r[dbg_pkg::MISC_BTM];
            btm_d_r <= {branch.from_addr, branch.to_addr};
        end
    end

    // ahb-lite: zero wait states, always okay
    always_comb begin
        rd_nxt = 32'h00000000;
        case (haddr)
            dbg_pkg::OFF_BP0: rd_nxt = bp_addr_r[0];
            dbg_pkg::OFF_BP1: rd_nxt = bp_addr_r[1];
            dbg_pkg::OFF_BP2: rd_nxt = bp_addr_r[2];
            dbg_pkg::OFF_BP3: rd_nxt = bp_addr_r[3];
            dbg_pkg::OFF_RSV4: rd_nxt = status_r;
            dbg_pkg::OFF_RSV5: rd_nxt = control_r;
            dbg_pkg::OFF_STATUS: rd_nxt = status_r;
            dbg_pkg::OFF_CONTROL: rd_nxt = control_r;
            dbg_pkg::OFF_MISC: rd_nxt = misc_r;
            dbg_pkg::OFF_LBR_TOS: rd_nxt = {30'h0, lbr_tos};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_addr_r <= 12'h000;
            a_wr_r <= 1'b0;
            a_act_r <= 1'b0;
            rd_r <= 32'h00000000;
        end else if (hready) begin
            a_addr_r <= haddr;
            a_wr_r <= hwrite;
            a_act_r <= hsel & htrans[1];
            rd_r <= rd_nxt;
        end
    end

    // branch stack entries are read from the registered address
    always_comb begin
        hrdata = rd_r;
        if (a_act_r && !a_wr_r) begin
            if (a_addr_r[11:4] == dbg_pkg::OFF_LBR_FROM[11:4] ||
                a_addr_r[11:4] == 8'h05) begin
                hrdata = lbr_from;
            end else if (a_addr_r[11:4] == dbg_pkg::OFF_LBR_TO[11:4] ||
                a_addr_r[11:4] == 8'h07) begin
                hrdata = lbr_to;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign debug_exception = dbx_r;
    assign breakpoint_exception = bpx_r;
    assign general_protection_fault = gpf_r;
    assign move_rd_data = mv_r;
    assign btm_valid = btm_v_r;
    assign btm_data = btm_d_r;
endmodule

// ===== bench/dbg_unit_properties.sv
// concurrent checks on the debug unit ports
`timescale 1ns/1ps
module dbg_unit_properties (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // core side
    input wire dbg_pkg::access_t access,
    input wire dbg_pkg::core_evt_t evt,
    input wire dbg_pkg::branch_t branch,
    // results
    input wire logic debug_exception,
    input wire logic breakpoint_exception,
    input wire logic general_protection_fault,
    input wire logic btm_valid
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic bad_move;
    logic db_cause;
    assign bad_move = evt.move_dr && !evt.real_mode && !evt.system_management_mode &&
        evt.current_privilege_level != 2'h0;
    // every source that may legally lead to a debug exception
    assign db_cause = access.valid || evt.move_dr ||
        (evt.insn_done && evt.step_flag) ||
        (evt.task_switch && evt.task_trap);
    property p_gpf;
        bad_move |=> general_protection_fault;
    endproperty
    a_gpf: assert property (p_gpf)
        else $error("unprivileged move without fault");
    property p_no_gpf;
        evt.move_dr && !bad_move |=> !general_protection_fault;
    endproperty
    a_no_gpf: assert property (p_no_gpf)
        else $error("privileged move faulted");
    property p_swbp;
        evt.soft_bp |-> ##1 breakpoint_exception;
    endproperty
    a_swbp: assert property (p_swbp)
        else $error("software breakpoint not raised");
    property p_swbp_cause;
        breakpoint_exception |-> $past(evt.soft_bp);
    endproperty
    a_swbp_cause: assert property (p_swbp_cause)
        else $error("breakpoint exception without cause");
    property p_swbp_only;
        evt.soft_bp && !db_cause |=> !debug_exception;
    endproperty
    a_swbp_only: assert property (p_swbp_only)
        else $error("software breakpoint raised debug exception");
    property p_step;
        evt.insn_done && evt.step_flag |=> debug_exception;
    endproperty
    a_step: assert property (p_step)
        else $error("single step did not trap");
    property p_task;
        evt.task_switch && evt.task_trap |=> debug_exception;
    endproperty
    a_task: assert property (p_task)
        else $error("task trap did not trap");
    property p_db_cause;
        debug_exception |-> $past(db_cause);
    endproperty
    a_db_cause: assert property (p_db_cause)
        else $error("debug exception without cause");
    property p_btm;
        btm_valid |-> $past(branch.valid);
    endproperty
    a_btm: assert property (p_btm)
        else $error("trace message without branch");
    c_db: cover property (access.valid ##1 debug_exception);
    c_gpf: cover property (general_protection_fault);
    c_btm: cover property (btm_valid);
endmodule

// ===== bench/core_model.sv
// core pipeline model issuing accesses, events and branches
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic hclk,
    // core side
    output dbg_pkg::access_t access,
    output dbg_pkg::core_evt_t evt,
    output dbg_pkg::branch_t branch
);
    initial begin
        access = '0;
        evt = '0;
        branch = '0;
    end
    // one slot of pulses, then idle; returns once results have landed
    task automatic issue(input dbg_pkg::access_t a,
                         input dbg_pkg::core_evt_t e,
                         input dbg_pkg::branch_t b);
        dbg_pkg::access_t q;
        dbg_pkg::branch_t p;
        q = a;
        p = b;
        @(posedge hclk);
        access <= a;
        evt <= e;
        branch <= b;
        @(posedge hclk);
        // idle access address and branch source inverted so a stale value cannot fake a match
        q.valid = 1'b0;
        q.lin_addr = ~a.lin_addr;
        p.valid = 1'b0;
        p.from_addr = ~b.from_addr;
        access <= q;
        evt <= '0;
        branch <= p;
        #1;
    endtask
endmodule

// ===== bench/tb.sv
// self-checking bench for the debug exception unit
`timescale 1ns/1ps
module tb;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, move_rd_data, r, mv, ctl, seed, x, xs;
    logic hready, hreadyout, hresp, btm_valid;
    logic debug_exception, breakpoint_exception, general_protection_fault;
    logic [63:0] btm_data;
    dbg_pkg::access_t access, a;
    dbg_pkg::core_evt_t evt, e;
    dbg_pkg::branch_t branch, b;
    logic [31:0] bpa [4];
    logic [31:0] offs [3];
    logic [1:0] szt [4];
    logic [3:0] h;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    int m;
    assign hready = hreadyout;
    dbg_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .access(access), .evt(evt),
        .branch(branch), .debug_exception(debug_exception),
        .breakpoint_exception(breakpoint_exception),
        .general_protection_fault(general_protection_fault),
        .move_rd_data(move_rd_data), .btm_valid(btm_valid),
        .btm_data(btm_data));
    core_model u_core (.hclk(hclk), .access(access), .evt(evt),
        .branch(branch));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // reference: which breakpoint conditions a one-byte access meets
    function automatic logic [3:0] conds(input dbg_pkg::access_t q);
        logic [3:0] c;
        logic [1:0] k;
        logic [1:0] s;
        longint len, lo;
        for (int n = 0; n < 4; n++) begin
            k = ctl[16 + 4 * n +: 2];
            s = ctl[18 + 4 * n +: 2];
            len = (s == dbg_pkg::LEN_1) ? 1 : (s == dbg_pkg::LEN_2) ? 2 :
                (s == dbg_pkg::LEN_4) ? 4 : 8;
            lo = bpa[n] & ~(len - 1);
            case (k)
                dbg_pkg::KIND_EXEC: c[n] = q.kind == dbg_pkg::ACC_FETCH;
                dbg_pkg::KIND_WR: c[n] = q.kind == dbg_pkg::ACC_WRITE;
                dbg_pkg::KIND_IO: c[n] = q.kind == dbg_pkg::ACC_IO;
                default: c[n] = q.kind[1] ^ q.kind[0]; // read or write
            endcase
            c[n] = c[n] && q.valid && q.lin_addr >= lo &&
                q.lin_addr < lo + len;
        end
        return c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= ad;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, 32'h0);
        chk(r, exp);
    endtask
    // clear status, run one slot, check pulses and recorded status
    task automatic probe(input dbg_pkg::access_t pa,
        input dbg_pkg::core_evt_t pe, input logic [2:0] ev,
        input logic [31:0] st);
        bus(1'b1, dbg_pkg::OFF_STATUS, 32'h0);
        u_core.issue(pa, pe, '0);
        mv = move_rd_data;
        chk({29'h0, debug_exception, breakpoint_exception,
            general_protection_fault}, {29'h0, ev});
        bus(1'b0, dbg_pkg::OFF_STATUS, 32'h0);
        chk(r & 32'he00f, st);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // run should need well under a thousand cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hresetn = 1'b0;
        seed = 32'h1f7c;
        offs = '{32'h0, 32'h3, 32'h4};
        szt = '{dbg_pkg::LEN_1, dbg_pkg::LEN_2, dbg_pkg::LEN_8, dbg_pkg::LEN_4};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(dbg_pkg::OFF_STATUS, dbg_pkg::STATUS_RST);
        rdc(dbg_pkg::OFF_CONTROL, dbg_pkg::CONTROL_RST);
        rdc(dbg_pkg::OFF_MISC, dbg_pkg::MISC_RST);
        for (int i = 0; i < 4; i++) begin
            rdc(12'(4 * i), 32'h0);
            bpa[i] = rnd() & 32'h0000fff8;
            bus(1'b1, 12'(4 * i), bpa[i]);
            rdc(12'(4 * i), bpa[i]);
        end
        bus(1'b1, 12'h030, 32'h5a5a5a5a);
        rdc(12'h030, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            m = (k + 1) % 4;
            bpa[m] = bpa[k];
            bus(1'b1, 12'(4 * m), bpa[m]);
            ctl = {{4{szt[k], 2'(k)}}, 16'h0} | (32'h2 << (2 * k));
            bus(1'b1, dbg_pkg::OFF_CONTROL, ctl);
            for (int j = 0; j < 12; j++) begin
                a = '0;
                a.valid = 1'b1;
                a.kind = dbg_pkg::acc_kind_t'(j % 4);
                a.lin_addr = bpa[k] + offs[j / 4];
                h = conds(a);
                probe(a, '0, h[k] ? 3'h4 : 3'h0, h[k] ? {28'h0, h} : 0);
            end
        end
        $display("test matching done");
        ctl = 32'h2;
        bus(1'b1, dbg_pkg::OFF_CONTROL, ctl);
        a = '0;
        a.valid = 1'b1;
        a.lin_addr = bpa[0];
        e = '0;
        e.resume_flag = 1'b1;
        probe(a, e, 3'h0, 32'h0);
        e.insn_done = 1'b1;
        probe('0, e, 3'h0, 32'h0);
        probe(a, '0, 3'h4, {28'h0, conds(a)});
        e = '0;
        e.insn_done = 1'b1;
        e.step_flag = 1'b1;
        probe('0, e, 3'h4, 32'h4000);
        bus(1'b1, dbg_pkg::OFF_CONTROL, 32'hff);
        e = '0;
        e.task_switch = 1'b1;
        e.task_trap = 1'b1;
        probe('0, e, 3'h4, 32'h8000);
        rdc(dbg_pkg::OFF_CONTROL, 32'haa);
        e = '0;
        e.soft_bp = 1'b1;
        probe('0, e, 3'h2, 32'h0);
        $display("test traps done");
        e = '0;
        e.move_dr = 1'b1;
        e.move_dr_idx = 3'h7;
        probe('0, e, 3'h0, 32'h0);
        chk(mv, 32'haa);
        x = rnd();
        e.move_dr_wr = 1'b1;
        e.move_dr_idx = 3'h0;
        e.move_dr_data = x;
        e.current_privilege_level = 2'h3;
        probe('0, e, 3'h1, 32'h0);
        rdc(dbg_pkg::OFF_BP0, bpa[0]);
        e.system_management_mode = 1'b1;
        probe('0, e, 3'h0, 32'h0);
        rdc(dbg_pkg::OFF_BP0, x);
        bus(1'b1, dbg_pkg::OFF_CONTROL, 32'h2000);
        e = '0;
        e.move_dr = 1'b1;
        e.move_dr_idx = 3'h6;
        probe('0, e, 3'h4, 32'h2000);
        $display("test moves done");
        bus(1'b1, dbg_pkg::OFF_MISC, 32'h7);
        xs = 32'h0;
        for (int i = 0; i < dbg_pkg::LBR_DEPTH; i++) begin
            b.valid = 1'b1;
            b.from_addr = rnd();
            b.to_addr = ~b.from_addr;
            xs ^= b.from_addr;
            u_core.issue('0, '0, b);
            chk({31'h0, btm_valid}, 32'h1);
            chk(btm_data[63:32], b.from_addr);
            chk(btm_data[31:0], b.to_addr);
        end
        // ring order is free, so check the set and the pairing
        for (int i = 0; i < dbg_pkg::LBR_DEPTH; i++) begin
            bus(1'b0, 12'(dbg_pkg::OFF_LBR_FROM + 4 * i), 32'h0);
            x = r;
            xs ^= x;
            rdc(12'(dbg_pkg::OFF_LBR_TO + 4 * i), ~x);
        end
        chk(xs, 32'h0);
        $display("test branches done");
        final_report();
    end
endmodule
bind dbg_unit dbg_unit_properties u_props (.hclk(hclk), .hresetn(hresetn),
    .access(access), .evt(evt), .branch(branch),
    .debug_exception(debug_exception),
    .breakpoint_exception(breakpoint_exception),
    .general_protection_fault(general_protection_fault),
    .btm_valid(btm_valid));
